// >>> core/cse_decoder.sv
`timescale 1ns/1ps
// Functional notes
// RULE_01: Sleep clears the power-down flag.
// RULE_02: Sleep sets the expiry flag.
// RULE_03: Sleep clears watchdog count and postscaler.
// RULE_04: After sleep, halt until a wake event.
// RULE_05: Base set of 75 always decodes.
// RULE_06: Extension adds eight indexed/indirect instructions.
// RULE_07: Extension inactive by default.
// RULE_08: Extension active only when config bit set.
// RULE_09: Most extended ops are pointer literal ops.
// RULE_10: Pointer add/sub have return variants for frame two.
// RULE_11: Add-and-return: six-bit literal, two cycles.
// RULE_12: Disabled extension opcodes act as unimplemented.
module cse_decoder
  import cse_pkg::*;
(
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_extended_set_config_bit,
  input  wire logic               i_instr_valid,
  input  wire logic [OPC_W-1:0]   i_opcode,
  input  wire logic               i_wdt_tick,
  input  wire logic               i_wake_event,
  output logic                    o_power_down_flag,
  output logic                    o_expiry_flag,
  output logic [WDT_W-1:0]        o_watchdog_count,
  output logic [PST_W-1:0]        o_postscaler,
  output logic                    o_sleeping,
  output logic                    o_busy,
  output cse_op_type              o_op,
  output logic [1:0]              o_ptr_sel,
  output logic [LIT8_W-1:0]       o_literal,
  output logic                    o_do_return,
  output logic                    o_indexed_mode,
  output logic                    o_unimplemented,
  output logic                    o_ext_enabled
);
  // Opcode field positions. The pointer instructions share one layout: an
  // opcode byte on top, a two-bit pointer select, then a six-bit literal.
  localparam int HI_MSB       = 15;
  localparam int HI_LSB       = 8;
  localparam int SEL_MSB      = 7;
  localparam int SEL_LSB      = 6;
  localparam int LIT6_MSB     = LIT6_W - 1;
  localparam int LIT8_MSB     = LIT8_W - 1;
  localparam int NIB_MSB      = 15;
  localparam int NIB_LSB      = 12;
  localparam int ACCESS_BIT   = 8;
  localparam int DEST_SRC_BIT = 7;
  localparam logic [1:0]               BUSY_IDLE = 2'h0;
  localparam logic [1:0]               SEL_NONE  = 2'h0;
  localparam logic [LIT8_W-LIT6_W-1:0] LIT_PAD   = '0;

  logic       ext_on;
  logic       second_word;
  logic [1:0] busy_cnt;
  // The configuration bit is caught once after reset, as a fuse would be, so a
  // change on the pin in mid-run cannot switch decoding halfway through code.
  logic       cfg_loaded;
  cse_op_type next_op;

  wire [7:0] hi         = i_opcode[HI_MSB:HI_LSB];
  wire [1:0] sel        = i_opcode[SEL_MSB:SEL_LSB];
  wire [3:0] nib        = i_opcode[NIB_MSB:NIB_LSB];
  wire       accept     = i_instr_valid && !o_sleeping && busy_cnt == BUSY_IDLE;
  wire       is_sleep   = i_opcode == OPC_SLEEP;
  wire       is_add     = hi == HI_ADD_PTR;
  wire       is_sub     = hi == HI_SUB_PTR;
  wire       is_push    = hi == HI_PUSH_LIT;
  wire       is_move    = hi == HI_MOVE_SRC;
  wire       is_call_via_wreg   = i_opcode == OPC_CALL_WREG;
  wire       is_ext     = is_add || is_sub || is_push || is_move || is_call_via_wreg; // RULE_06
  wire       is_ret     = (is_add || is_sub) && sel == SEL_FRAME_TWO; // RULE_10
  wire       is_second  = second_word && nib == NIB_SECOND;
  wire       take_sleep = accept && is_sleep && !is_second;
  wire       pst_wrap   = i_wdt_tick && (&o_postscaler);

  // The second word of a move is matched first: its top nibble would otherwise
  // be read as an unrelated base opcode.
  always_comb begin
    if (is_second)
      next_op = CSE_OP_BASE;
    else if (is_sleep)
      next_op = CSE_OP_SLEEP;
    else if (is_ext && !ext_on)
      next_op = CSE_OP_UNIMPL; // RULE_12
    else if (is_ret)
      next_op = is_add ? CSE_OP_ADD_RET : CSE_OP_SUB_RET; // RULE_11
    else if (is_add)
      next_op = CSE_OP_ADD_PTR; // RULE_09
    else if (is_sub)
      next_op = CSE_OP_SUB_PTR; // RULE_09
    else if (is_push)
      next_op = CSE_OP_PUSH_LIT; // RULE_09
    else if (is_move)
      next_op = i_opcode[DEST_SRC_BIT] ? CSE_OP_MOVE_TO_SRC : CSE_OP_MOVE_TO_FILE;
    else if (is_call_via_wreg)
      next_op = CSE_OP_CALL_WREG;
    else
      next_op = CSE_OP_BASE; // RULE_05
  end

  // The push literal uses the whole low byte; the pointer literals are six bits
  // and are zero-extended so the consumer never sees select bits as data.
  wire [LIT8_W-1:0] next_lit = is_push ? i_opcode[LIT8_MSB:0]
                               : {LIT_PAD, i_opcode[LIT6_MSB:0]};
  wire two_word = ext_on && is_move && !is_second;
  // Returns, calls and moves take a second cycle; the next word is refused
  // then rather than queued, since there is no buffer in front of decode.
  wire two_cyc  = ext_on && !is_second && (is_ret || is_move || is_call_via_wreg);
  // With the extension on, indexed access applies to any non-extension opcode with the access bit clear and a low byte up to INDEX_LIMIT, sleep included.
  wire idx = ext_on && !is_ext && !i_opcode[ACCESS_BIT]
             && i_opcode[LIT8_MSB:0] <= INDEX_LIMIT;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      ext_on <= 1'b0; // RULE_07
      cfg_loaded <= 1'b0;
    end else if (!cfg_loaded) begin
      ext_on <= i_extended_set_config_bit; // RULE_08
      cfg_loaded <= 1'b1;
    end
  end

  // Wake leaves both flags alone; whoever handles a watchdog wake updates them.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_power_down_flag <= 1'b1;
      o_expiry_flag <= 1'b1;
    end else if (take_sleep) begin
      o_power_down_flag <= 1'b0; // RULE_01
      o_expiry_flag <= 1'b1; // RULE_02
    end
  end

  // Sleep is only accepted while awake, so a set and a clear never meet.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst)
      o_sleeping <= 1'b0;
    else if (take_sleep)
      o_sleeping <= 1'b1; // RULE_04
    else if (o_sleeping && i_wake_event)
      o_sleeping <= 1'b0; // RULE_04
  end

  // Sleep takes priority over a tick in the same cycle, so the count restarts
  // from zero rather than from one.
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_watchdog_count <= '0;
      o_postscaler <= '0;
    end else if (take_sleep) begin
      o_watchdog_count <= '0; // RULE_03
      o_postscaler <= '0; // RULE_03
    end else begin
      if (i_wdt_tick)
        o_postscaler <= o_postscaler + 1'b1;
      if (pst_wrap)
        o_watchdog_count <= o_watchdog_count + 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_op <= CSE_OP_NONE;
      o_ptr_sel <= SEL_NONE;
      o_literal <= '0;
      o_do_return <= 1'b0;
      o_indexed_mode <= 1'b0;
      o_unimplemented <= 1'b0;
    end else begin
      o_op <= accept ? next_op : CSE_OP_NONE;
      o_ptr_sel <= accept ? sel : SEL_NONE;
      o_literal <= accept ? next_lit : '0;
      o_do_return <= accept && is_ret && ext_on; // RULE_10
      o_indexed_mode <= accept && idx; // RULE_06
      o_unimplemented <= accept && next_op == CSE_OP_UNIMPL;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_busy <= 1'b0;
      busy_cnt <= BUSY_IDLE;
      second_word <= 1'b0;
    end else begin
      if (accept)
        second_word <= two_word;
      if (accept && two_cyc)
        busy_cnt <= RETURN_CYCLES - 2'h1; // RULE_11
      else if (busy_cnt != BUSY_IDLE)
        busy_cnt <= busy_cnt - 2'h1;
      o_busy <= accept && two_cyc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst)
      o_ext_enabled <= 1'b0;
    else
      o_ext_enabled <= ext_on;
  end
endmodule

// >>> core/cse_pkg.sv
package cse_pkg;
  localparam int OPC_W = 16;
  localparam int PTR_W = 12;
  localparam int LIT6_W = 6;
  localparam int LIT8_W = 8;
  localparam int WDT_W = 8;
  localparam int PST_W = 7;
  localparam int BASE_SET_COUNT = 75;
  localparam int EXT_SET_COUNT = 8;
  localparam logic [15:0] OPC_SLEEP = 16'h0003;
  localparam logic [15:0] OPC_CALL_WREG = 16'h0014;
  localparam logic [7:0] HI_ADD_PTR = 8'he8;
  localparam logic [7:0] HI_SUB_PTR = 8'he9;
  localparam logic [7:0] HI_PUSH_LIT = 8'hea;
  localparam logic [7:0] HI_MOVE_SRC = 8'heb;
  localparam logic [3:0] NIB_SECOND = 4'hf;
  localparam logic [1:0] SEL_FRAME_TWO = 2'h3;
  localparam logic [7:0] INDEX_LIMIT = 8'h5f;
  localparam logic [1:0] RETURN_CYCLES = 2'h2;
  typedef enum logic [3:0] {
    CSE_OP_NONE, CSE_OP_BASE, CSE_OP_SLEEP, CSE_OP_ADD_PTR, CSE_OP_SUB_PTR,
    CSE_OP_ADD_RET, CSE_OP_SUB_RET, CSE_OP_CALL_WREG, CSE_OP_MOVE_TO_FILE,
    CSE_OP_MOVE_TO_SRC, CSE_OP_PUSH_LIT, CSE_OP_UNIMPL
  } cse_op_type;
endpackage

// >>> testbench/cse_decoder_assertions.sv
`timescale 1ns/1ps
module cse_chk
  import cse_pkg::*;
(
  input wire logic i_clock, i_sys_rst, i_extended_set_config_bit, i_instr_valid, i_wake_event,
  input wire logic [15:0] i_opcode,
  input wire logic o_power_down_flag, o_expiry_flag, o_sleeping, o_busy, o_do_return,
  input wire logic o_unimplemented, o_ext_enabled,
  input wire logic [7:0] o_watchdog_count, o_literal,
  input wire logic [6:0] o_postscaler,
  input wire cse_op_type o_op
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  wire t = i_instr_valid && !o_sleeping && !o_busy;
  wire e = t && o_ext_enabled;
  wire x = e && i_opcode[7:6] == SEL_FRAME_TWO;
  wire [7:0] h = i_opcode[15:8];
  wire [7:0] k = i_opcode[7:0];
  property p_sl; t && i_opcode == OPC_SLEEP |=> !o_power_down_flag && o_expiry_flag
    && o_sleeping && o_watchdog_count == 0 && o_postscaler == 0; endproperty
  a_sl: assert property (p_sl) else $error("sleep");
  property p_hd; o_sleeping && !i_wake_event |=> o_sleeping && o_op == CSE_OP_NONE; endproperty
  a_hd: assert property (p_hd) else $error("hold");
  property p_cf; $fell(i_sys_rst) |=> ##1 o_ext_enabled == $past(i_extended_set_config_bit, 2);
  endproperty
  a_cf: assert property (p_cf) else $error("cfg");
  property p_ar; x && h == HI_ADD_PTR |=> o_op == CSE_OP_ADD_RET && o_busy && o_do_return
    && o_literal == ($past(k) & 8'h3f) ##1 o_op == CSE_OP_NONE; endproperty
  a_ar: assert property (p_ar) else $error("addret");
  property p_sr; x && h == HI_SUB_PTR |=> o_op == CSE_OP_SUB_RET && o_do_return; endproperty
  a_sr: assert property (p_sr) else $error("subret");
  property p_ph; e && h == HI_PUSH_LIT |=> o_op == CSE_OP_PUSH_LIT && o_literal == $past(k); endproperty
  a_ph: assert property (p_ph) else $error("push");
  property p_un; t && !o_ext_enabled && h[7:1] == 7'h74 |=> o_unimplemented && !o_do_return; endproperty
  a_un: assert property (p_un) else $error("unimpl");
  property p_bs; t && h == 8'h0f |=> o_op == CSE_OP_BASE && !o_unimplemented; endproperty
  a_bs: assert property (p_bs) else $error("base");
  cover property (o_do_return);
  cover property (o_unimplemented);
  cover property (o_sleeping && i_wake_event);
endmodule
bind cse_decoder cse_chk u_chk (.*);

// >>> testbench/cse_decoder_test.sv
`timescale 1ns/1ps
module cse_decoder_test
  import cse_pkg::*;
;
  logic i_clock = 1'h0, i_sys_rst = 1'h1, i_extended_set_config_bit, i_instr_valid = 1'h0;
  logic i_wdt_tick = 1'h0, i_wake_event = 1'h0, o_power_down_flag, o_expiry_flag, o_sleeping;
  logic o_busy, o_do_return, o_indexed_mode, o_unimplemented, o_ext_enabled;
  logic [15:0] i_opcode = 16'h0;
  logic [7:0] o_watchdog_count, o_literal, h;
  logic [6:0] o_postscaler;
  logic [1:0] o_ptr_sel;
  logic [16:0] r = 17'h174d5;
  logic [15:0] w;
  cse_op_type o_op;
  cse_op_type eo [4] = '{CSE_OP_BASE, CSE_OP_ADD_RET, CSE_OP_SUB_RET, CSE_OP_PUSH_LIT};
  int errors = 0, samples_checked = 0, i;
  always #5 i_clock = ~i_clock;
  cse_decoder u_dut (.*);
  function automatic logic [16:0] nx(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function automatic logic [7:0] exp_lit(input logic [15:0] c);
    return c[15:8] == HI_PUSH_LIT ? c[7:0] : {2'h0, c[5:0]};
  endfunction
  task chk(input logic [19:0] s, x);
    samples_checked++;
    if (s !== x) begin
      errors++;
      $display("Error %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task results;
    $display("errors %0d checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task rst(input logic c);
    i_sys_rst = 1'h1;
    i_extended_set_config_bit = c;
    repeat (16) @(negedge i_clock);
    i_sys_rst = 1'h0;
    repeat (2) @(negedge i_clock);
    chk({o_ext_enabled, o_power_down_flag, o_expiry_flag}, {c, 2'h3});
  endtask
  // Valid drops for a cycle after each word, so two-cycle ops always get their gap.
  task run(input logic [15:0] c);
    @(negedge i_clock);
    i_instr_valid = 1'h1;
    i_opcode = c;
    @(negedge i_clock);
    i_instr_valid = 1'h0;
  endtask
  initial begin
    rst(1'h1);
    for (i = 0; i < 40; i++) begin
      r = nx(r);
      h = i[1:0] == 2'h0 ? 8'h0f : 8'he7 + {6'h0, i[1:0]};
      w = {h, i < 4 ? 8'hc0 : {2'h3, r[5:0]}};
      run(w);
      chk({o_op, o_do_return}, {eo[i[1:0]], h[7:1] == 7'h74});
      chk({o_ptr_sel, o_literal, o_busy}, {w[7:6], exp_lit(w), h[7:1] == 7'h74});
    end
    run(16'heb05);
    chk({o_op, o_busy}, {CSE_OP_MOVE_TO_FILE, 1'h1});
    run(16'hf123);
    chk({o_op, o_unimplemented}, {CSE_OP_BASE, 1'h0});
    run(OPC_CALL_WREG);
    chk({o_op, o_busy}, {CSE_OP_CALL_WREG, 1'h1});
    run(16'he845);
    chk({o_op, o_ptr_sel, o_literal, o_do_return}, {CSE_OP_ADD_PTR, 10'h105, 1'h0});
    run(16'h0e10);
    chk(o_indexed_mode, 1'h1);
    i_wdt_tick = 1'h1;
    repeat (131) @(negedge i_clock);
    i_wdt_tick = 1'h0;
    chk({o_watchdog_count, o_postscaler}, {8'h01, 7'h03});
    run(OPC_SLEEP);
    chk({o_power_down_flag, o_expiry_flag, o_sleeping, o_watchdog_count, o_postscaler}, 20'h18000);
    run(16'h0f11);
    chk(o_op, CSE_OP_NONE);
    i_wake_event = 1'h1;
    @(negedge i_clock);
    i_wake_event = 1'h0;
    chk(o_sleeping, 1'h0);
    rst(1'h0);
    run(16'h0e10);
    chk(o_indexed_mode, 1'h0);
    run({HI_ADD_PTR, 8'hc5});
    chk({o_unimplemented, o_do_return}, 2'h2);
    results();
  end
  initial begin
    #20000;
    errors++;
    results();
  end
endmodule
